// ==== logic/swc_defines.vh ====
// register map, field positions, reset values and codes of the sleep
// and wake controller; assumes a 32-bit AXI4-Lite register bus
`ifndef SWC_DEFINES_VH
`define SWC_DEFINES_VH

// byte addresses of the registers
`define SWC_ADDR_CTRL 8'h00
`define SWC_ADDR_IRQ_EN 8'h04
`define SWC_ADDR_STATUS 8'h08
`define SWC_ADDR_WDT_PERIOD 8'h0c
`define SWC_ADDR_ID0 8'h10
`define SWC_ADDR_ID3 8'h1c

// control register fields
`define SWC_CTRL_WDT_SOFT_EN 0
`define SWC_CTRL_GIE 1
`define SWC_CTRL_TMR_ASYNC 2
`define SWC_CTRL_ADC_RC 3
`define SWC_CTRL_XTAL_OSC 4
`define SWC_CTRL_CODE_PROT 5
`define SWC_CTRL_W 6
`define SWC_CTRL_RESET 6'h20

// status register fields
`define SWC_ST_TIMEOUT_N 0
`define SWC_ST_POWER_DOWN_N 1
`define SWC_ST_SLEEPING 2
`define SWC_ST_WDT_ON 3
`define SWC_ST_IRQ_LSB 8

// wake sources, one bit each
`define SWC_IRQ_W 9
`define SWC_IRQ_TMR 0
`define SWC_IRQ_ADC 2
`define SWC_IRQ_EN_RESET 9'h000

// watchdog, identification and vector values
`define SWC_WDT_PERIOD_RESET 16'h0200
`define SWC_ID_W 7
`define SWC_PC_W 13
`define SWC_IRQ_VECTOR 13'h0004

// answers on the bus
`define SWC_RESP_OKAY 2'b00
`define SWC_RESP_SLVERR 2'b10

`endif

// ==== logic/swc_sleep_ctrl.v ====
// sleep and wake controller: sleep entry, watchdog, status flags,
// wake sources, resume and vector branch, id words and code protect.
// assumes a core on CLK_SYS that pulses SLEEP_EXEC and WATCHDOG_CLEAR_INSTR_EXEC and
// level interrupt flags from the sources; pins arrive asynchronously.
`timescale 1ns/10ps
`default_nettype none
`include "swc_defines.vh"

module swc_sleep_ctrl #(
   parameter OST_CYCLES = 1024
) (
   input wire CLK_SYS,
   input wire ARST_N,
   // axi4-lite slave
   input wire [7:0] S_AXI_AWADDR,
   input wire S_AXI_AWVALID,
   output reg S_AXI_AWREADY,
   input wire [31:0] S_AXI_WDATA,
   input wire [3:0] S_AXI_WSTRB,
   input wire S_AXI_WVALID,
   output reg S_AXI_WREADY,
   output reg [1:0] S_AXI_BRESP,
   output reg S_AXI_BVALID,
   input wire S_AXI_BREADY,
   input wire [7:0] S_AXI_ARADDR,
   input wire S_AXI_ARVALID,
   output reg S_AXI_ARREADY,
   output reg [31:0] S_AXI_RDATA,
   output reg [1:0] S_AXI_RRESP,
   output reg S_AXI_RVALID,
   input wire S_AXI_RREADY,
   // core side
   input wire SLEEP_EXEC,
   input wire [`SWC_PC_W-1:0] SLEEP_PC,
   input wire WATCHDOG_CLEAR_INSTR_EXEC,
   output reg CORE_RUN,
   output reg PREFETCH_REQ,
   output reg [`SWC_PC_W-1:0] PREFETCH_ADDR,
   output reg RESUME_PULSE,
   output reg VECTOR_REQ,
   output reg [`SWC_PC_W-1:0] VECTOR_ADDR,
   // wake sources and pins
   input wire [`SWC_IRQ_W-1:0] IRQ_FLAGS,
   input wire EXTERNAL_RESET_PIN_N,
   input wire WATCHDOG_CONFIG_ENABLE,
   input wire PROG_MODE,
   // power and reset outputs
   output reg OSC_DRIVER_EN,
   output reg IO_HOLD,
   output reg DEVICE_RESET,
   output reg WDT_RESET,
   output reg RESET_PIN_DRIVE_EN,
   output reg ERASE_ALL,
   output reg VERIFY_READ_EN
);

   localparam ST_RUN = 2'd0;
   localparam ST_SLEEP = 2'd1;
   localparam ST_OST = 2'd2;
   localparam ST_RESUME = 2'd3;
   localparam OST_W = 16;

   // pin and source synchronisers
   reg [`SWC_IRQ_W-1:0] irq_s1_q, irq_s2_q;
   reg external_reset_pin_n_s1_q, external_reset_pin_n_s2_q, wcfg_s1_q, wcfg_s2_q, prog_s1_q, prog_s2_q;
   // register state
   reg [`SWC_CTRL_W-1:0] ctrl_q;
   reg [`SWC_IRQ_W-1:0] irq_en_q;
   reg [15:0] wdt_period_q;
   reg [`SWC_ID_W-1:0] id_mem_q [0:3];
   reg power_down_flag_n_q, timeout_flag_n_q;
   // sequencer state
   reg [1:0] state_q;
   reg [15:0] wdt_cnt_q;
   reg [OST_W-1:0] ost_cnt_q;
   reg wake_by_irq_q;
   // bus state
   reg aw_have_q, w_have_q;
   reg [7:0] aw_addr_q;
   reg [31:0] w_data_q;
   reg [3:0] w_strb_q;
   integer i;

   // two flops before any logic looks at outside levels
   always @(posedge CLK_SYS or negedge ARST_N) begin
      if (!ARST_N) begin
         {irq_s2_q, irq_s1_q} <= {(2*`SWC_IRQ_W){1'b0}};
         {external_reset_pin_n_s2_q, external_reset_pin_n_s1_q} <= 2'h3;
         {wcfg_s2_q, wcfg_s1_q} <= 2'h0;
         {prog_s2_q, prog_s1_q} <= 2'h0;
      end else begin
         {irq_s2_q, irq_s1_q} <= {irq_s1_q, IRQ_FLAGS};
         {external_reset_pin_n_s2_q, external_reset_pin_n_s1_q} <= {external_reset_pin_n_s1_q, EXTERNAL_RESET_PIN_N};
         {wcfg_s2_q, wcfg_s1_q} <= {wcfg_s1_q, WATCHDOG_CONFIG_ENABLE};
         {prog_s2_q, prog_s1_q} <= {prog_s1_q, PROG_MODE};
      end
   end

   // wake qualification
   reg [`SWC_IRQ_W-1:0] src_ok;
   wire irq_pending, wdt_on, wdt_expire, global_irq_enable;
   always @* begin
      src_ok = {`SWC_IRQ_W{1'b1}};
      src_ok[`SWC_IRQ_TMR] = ctrl_q[`SWC_CTRL_TMR_ASYNC];
      src_ok[`SWC_IRQ_ADC] = ctrl_q[`SWC_CTRL_ADC_RC];
   end
   // individual enables and timer/adc source qualifiers only, no global gate
   assign irq_pending = |(irq_s2_q & irq_en_q & src_ok);
   assign wdt_on = wcfg_s2_q | ctrl_q[`SWC_CTRL_WDT_SOFT_EN];
   assign wdt_expire = wdt_on && (state_q != ST_OST)
      && (wdt_cnt_q >= wdt_period_q);
   assign global_irq_enable = ctrl_q[`SWC_CTRL_GIE];
   // sleep taken only in run; a pending wake with no global enable skips it
   wire sleep_noop = SLEEP_EXEC && irq_pending && !global_irq_enable;
   wire sleep_take = SLEEP_EXEC && !sleep_noop && (state_q == ST_RUN);
   wire pin_reset = !external_reset_pin_n_s2_q;
   // bus decode
   wire wr_fire = aw_have_q && w_have_q && !S_AXI_BVALID;
   wire ar_fire = S_AXI_ARVALID && S_AXI_ARREADY;
   wire wr_id = (aw_addr_q[7:4] == 4'h1) && (aw_addr_q[1:0] == 2'b00);
   wire rd_id = (S_AXI_ARADDR[7:4] == 4'h1)
      && (S_AXI_ARADDR[1:0] == 2'b00);

   // true when an address names a plain register
   function is_reg;
      input [7:0] a;
      begin
         is_reg = (a == `SWC_ADDR_CTRL) || (a == `SWC_ADDR_IRQ_EN)
            || (a == `SWC_ADDR_STATUS) || (a == `SWC_ADDR_WDT_PERIOD);
      end
   endfunction

   // merge written bytes under the strobes
   function [31:0] merge;
      input [31:0] old;
      input [31:0] nw;
      input [3:0] strb;
      integer b;
      begin
         merge = old;
         for (b = 0; b < 4; b = b + 1) begin
            if (strb[b]) begin
               merge[b*8 +: 8] = nw[b*8 +: 8];
            end
         end
      end
   endfunction

   wire [31:0] wr_word = merge(32'h0000_0000, w_data_q, w_strb_q);
   wire [31:0] ctrl_new = merge({26'h0, ctrl_q}, w_data_q, w_strb_q);
   wire ctrl_wr = wr_fire && (aw_addr_q == `SWC_ADDR_CTRL);

   // write channel: address and data taken in either order
   always @(posedge CLK_SYS or negedge ARST_N) begin
      if (!ARST_N) begin
         aw_have_q <= 1'b0;
         w_have_q <= 1'b0;
         aw_addr_q <= 8'h00;
         w_data_q <= 32'h0000_0000;
         w_strb_q <= 4'h0;
         S_AXI_AWREADY <= 1'b1;
         S_AXI_WREADY <= 1'b1;
         S_AXI_BVALID <= 1'b0;
         S_AXI_BRESP <= `SWC_RESP_OKAY;
      end else begin
         if (S_AXI_AWVALID && S_AXI_AWREADY) begin
            aw_have_q <= 1'b1;
            aw_addr_q <= S_AXI_AWADDR;
            S_AXI_AWREADY <= 1'b0;
         end
         if (S_AXI_WVALID && S_AXI_WREADY) begin
            w_have_q <= 1'b1;
            w_data_q <= S_AXI_WDATA;
            w_strb_q <= S_AXI_WSTRB;
            S_AXI_WREADY <= 1'b0;
         end
         if (wr_fire) begin
            aw_have_q <= 1'b0;
            w_have_q <= 1'b0;
            S_AXI_BVALID <= 1'b1;
            // id words refuse writes outside program mode
            S_AXI_BRESP <= ((is_reg(aw_addr_q)
               && aw_addr_q != `SWC_ADDR_STATUS) || (wr_id && prog_s2_q))
               ? `SWC_RESP_OKAY : `SWC_RESP_SLVERR;
         end
         if (S_AXI_BVALID && S_AXI_BREADY) begin
            S_AXI_BVALID <= 1'b0;
            S_AXI_AWREADY <= 1'b1;
            S_AXI_WREADY <= 1'b1;
         end
      end
   end

   // register writes
   always @(posedge CLK_SYS or negedge ARST_N) begin
      if (!ARST_N) begin
         ctrl_q <= `SWC_CTRL_RESET;
         irq_en_q <= `SWC_IRQ_EN_RESET;
         wdt_period_q <= `SWC_WDT_PERIOD_RESET;
         for (i = 0; i < 4; i = i + 1) begin
            id_mem_q[i] <= {`SWC_ID_W{1'b0}};
         end
      end else if (wr_fire) begin
         case (aw_addr_q)
            `SWC_ADDR_CTRL: ctrl_q <= ctrl_new[`SWC_CTRL_W-1:0];
            `SWC_ADDR_IRQ_EN: irq_en_q <= wr_word[`SWC_IRQ_W-1:0];
            `SWC_ADDR_WDT_PERIOD: wdt_period_q <= wr_word[15:0];
            default: begin
               // only seven bits kept, program mode only
               if (wr_id && prog_s2_q && w_strb_q[0])
                  id_mem_q[aw_addr_q[3:2]] <= w_data_q[`SWC_ID_W-1:0];
            end
         endcase
      end
   end

   // read channel: one read at a time, data one cycle after address
   always @(posedge CLK_SYS or negedge ARST_N) begin
      if (!ARST_N) begin
         S_AXI_ARREADY <= 1'b1;
         S_AXI_RVALID <= 1'b0;
         S_AXI_RDATA <= 32'h0000_0000;
         S_AXI_RRESP <= `SWC_RESP_OKAY;
      end else begin
         if (ar_fire) begin
            S_AXI_ARREADY <= 1'b0;
            S_AXI_RVALID <= 1'b1;
            S_AXI_RRESP <= `SWC_RESP_OKAY;
            S_AXI_RDATA <= 32'h0000_0000;
            case (S_AXI_ARADDR)
               `SWC_ADDR_CTRL: S_AXI_RDATA[`SWC_CTRL_W-1:0] <= ctrl_q;
               `SWC_ADDR_IRQ_EN: S_AXI_RDATA[`SWC_IRQ_W-1:0] <= irq_en_q;
               `SWC_ADDR_STATUS: S_AXI_RDATA <= {15'h0000, irq_s2_q,
                  4'h0, wdt_on, (state_q != ST_RUN),
                  power_down_flag_n_q, timeout_flag_n_q};
               `SWC_ADDR_WDT_PERIOD: S_AXI_RDATA[15:0] <= wdt_period_q;
               default: begin
                  // id words hidden during normal execution
                  if (rd_id && prog_s2_q)
                     S_AXI_RDATA[`SWC_ID_W-1:0] <=
                        id_mem_q[S_AXI_ARADDR[3:2]];
                  else
                     S_AXI_RRESP <= `SWC_RESP_SLVERR;
               end
            endcase
         end
         if (S_AXI_RVALID && S_AXI_RREADY) begin
            S_AXI_RVALID <= 1'b0;
            S_AXI_ARREADY <= 1'b1;
         end
      end
   end

   // sleep sequencer, watchdog and status flags
   always @(posedge CLK_SYS or negedge ARST_N) begin
      if (!ARST_N) begin
         state_q <= ST_RUN;
         wdt_cnt_q <= 16'h0000;
         ost_cnt_q <= {OST_W{1'b0}};
         wake_by_irq_q <= 1'b0;
         power_down_flag_n_q <= 1'b1;
         timeout_flag_n_q <= 1'b1;
         CORE_RUN <= 1'b1;
         OSC_DRIVER_EN <= 1'b1;
         IO_HOLD <= 1'b0;
         PREFETCH_ADDR <= {`SWC_PC_W{1'b0}};
         VECTOR_ADDR <= `SWC_IRQ_VECTOR;
         {PREFETCH_REQ, RESUME_PULSE, VECTOR_REQ, DEVICE_RESET,
            WDT_RESET} <= 5'h00;
      end else begin
         {PREFETCH_REQ, RESUME_PULSE, VECTOR_REQ, DEVICE_RESET,
            WDT_RESET} <= 5'h00;
         // watchdog count, stops and holds at the period until cleared
         if (wdt_on && wdt_cnt_q < wdt_period_q)
            wdt_cnt_q <= wdt_cnt_q + 16'h0001;
         else if (!wdt_on)
            wdt_cnt_q <= 16'h0000;
         if (WATCHDOG_CLEAR_INSTR_EXEC && state_q == ST_RUN) begin
            wdt_cnt_q <= 16'h0000;
            timeout_flag_n_q <= 1'b1;
            power_down_flag_n_q <= 1'b1;
         end
         if (pin_reset) begin
            // pin wake or pin reset restarts the device
            state_q <= ST_RUN;
            wdt_cnt_q <= 16'h0000;
            DEVICE_RESET <= 1'b1;
            CORE_RUN <= 1'b1;
            OSC_DRIVER_EN <= 1'b1;
            IO_HOLD <= 1'b0;
         end else begin
            case (state_q)
               ST_RUN: begin
                  if (sleep_take) begin
                     state_q <= ST_SLEEP;
                     wdt_cnt_q <= 16'h0000;
                     power_down_flag_n_q <= 1'b0;
                     timeout_flag_n_q <= 1'b1;
                     CORE_RUN <= 1'b0;
                     OSC_DRIVER_EN <= 1'b0;
                     IO_HOLD <= 1'b1;
                     PREFETCH_REQ <= 1'b1;
                     PREFETCH_ADDR <= SLEEP_PC + 13'h0001;
                  end else if (wdt_expire) begin
                     WDT_RESET <= 1'b1;
                     timeout_flag_n_q <= 1'b0;
                     wdt_cnt_q <= 16'h0000;
                  end
                  // sleep_noop leaves flags and watchdog alone
               end
               ST_SLEEP: begin
                  // wake at once on pending source
                  if (irq_pending || wdt_expire) begin
                     wdt_cnt_q <= 16'h0000;
                     wake_by_irq_q <= irq_pending;
                     if (!irq_pending)
                        timeout_flag_n_q <= 1'b0;
                     OSC_DRIVER_EN <= 1'b1;
                     ost_cnt_q <= {OST_W{1'b0}};
                     state_q <= ctrl_q[`SWC_CTRL_XTAL_OSC] ? ST_OST
                        : ST_RESUME;
                  end
               end
               ST_OST: begin
                  // hold watchdog clear during start-up count
                  wdt_cnt_q <= 16'h0000;
                  if (ost_cnt_q == OST_CYCLES[OST_W-1:0] - 16'h0001)
                     state_q <= ST_RESUME;
                  else
                     ost_cnt_q <= ost_cnt_q + 16'h0001;
               end
               ST_RESUME: begin
                  state_q <= ST_RUN;
                  CORE_RUN <= 1'b1;
                  IO_HOLD <= 1'b0;
                  RESUME_PULSE <= 1'b1;
                  // branch after prefetched word when enabled
                  VECTOR_REQ <= wake_by_irq_q & global_irq_enable;
               end
               default: state_q <= ST_RUN;
            endcase
         end
      end
   end

   // code protect, erase request and fixed reset pin drive
   always @(posedge CLK_SYS or negedge ARST_N) begin
      if (!ARST_N) begin
         ERASE_ALL <= 1'b0;
         VERIFY_READ_EN <= 1'b0;
         RESET_PIN_DRIVE_EN <= 1'b0;
      end else begin
         ERASE_ALL <= ctrl_wr && ctrl_q[`SWC_CTRL_CODE_PROT]
            && !ctrl_new[`SWC_CTRL_CODE_PROT];
         VERIFY_READ_EN <= !ctrl_q[`SWC_CTRL_CODE_PROT];
         // the reset pin is input only
         RESET_PIN_DRIVE_EN <= 1'b0;
      end
   end

endmodule
`default_nettype wire

// ==== sim/swc_sleep_sva.sv ====
// checker of the sleep controller's core-side and power outputs
// assumes it is bound to swc_sleep_ctrl and sees only its ports
`timescale 1ns/10ps
`default_nettype none
`include "swc_defines.vh"

module swc_sleep_sva (
   input wire logic CLK_SYS,
   input wire logic ARST_N,
   input wire logic SLEEP_EXEC,
   input wire logic [`SWC_PC_W-1:0] SLEEP_PC,
   input wire logic CORE_RUN,
   input wire logic PREFETCH_REQ,
   input wire logic [`SWC_PC_W-1:0] PREFETCH_ADDR,
   input wire logic RESUME_PULSE,
   input wire logic VECTOR_REQ,
   input wire logic [`SWC_PC_W-1:0] VECTOR_ADDR,
   input wire logic OSC_DRIVER_EN,
   input wire logic IO_HOLD,
   input wire logic DEVICE_RESET,
   input wire logic RESET_PIN_DRIVE_EN,
   input wire logic ERASE_ALL,
   input wire logic VERIFY_READ_EN
);
   default clocking dc @(posedge CLK_SYS); endclocking
   default disable iff (!ARST_N);

   // sleep entry: caused by the sleep pulse, all sleep outputs at once
   a_sleep_entry: assert property (
      $fell(CORE_RUN) |-> $past(SLEEP_EXEC) && !OSC_DRIVER_EN
         && IO_HOLD && PREFETCH_REQ)
      else $error("sleep entry outputs wrong");
   a_prefetch_next: assert property (
      PREFETCH_REQ |-> $past(SLEEP_EXEC)
         && (PREFETCH_ADDR - $past(SLEEP_PC) == 13'h1))
      else $error("prefetch address not next word");
   a_asleep_state: assert property (
      !OSC_DRIVER_EN |-> IO_HOLD && !CORE_RUN)
      else $error("oscillator off outside sleep");
   a_hold_release: assert property (
      $fell(IO_HOLD) |-> RESUME_PULSE || DEVICE_RESET
         || $past(DEVICE_RESET))
      else $error("io hold dropped without wake");
   a_pin_undriven: assert property (
      !RESET_PIN_DRIVE_EN)
      else $error("reset pin driven");
   a_vector_addr: assert property (
      VECTOR_REQ |-> RESUME_PULSE && VECTOR_ADDR == `SWC_IRQ_VECTOR)
      else $error("vector branch wrong");
   a_resume_run: assert property (
      RESUME_PULSE |-> CORE_RUN && OSC_DRIVER_EN && $past(IO_HOLD))
      else $error("resume not from sleep");
   a_erase_verify: assert property (
      ERASE_ALL |-> ##[0:1] VERIFY_READ_EN)
      else $error("erase without verify access");

   c_sleep: cover property ($fell(CORE_RUN));
   c_vector: cover property (VECTOR_REQ);
   c_pin: cover property (DEVICE_RESET);
endmodule

bind swc_sleep_ctrl swc_sleep_sva u_sva (
   .CLK_SYS(CLK_SYS), .ARST_N(ARST_N), .SLEEP_EXEC(SLEEP_EXEC),
   .SLEEP_PC(SLEEP_PC), .CORE_RUN(CORE_RUN),
   .PREFETCH_REQ(PREFETCH_REQ), .PREFETCH_ADDR(PREFETCH_ADDR),
   .RESUME_PULSE(RESUME_PULSE), .VECTOR_REQ(VECTOR_REQ),
   .VECTOR_ADDR(VECTOR_ADDR), .OSC_DRIVER_EN(OSC_DRIVER_EN),
   .IO_HOLD(IO_HOLD), .DEVICE_RESET(DEVICE_RESET),
   .RESET_PIN_DRIVE_EN(RESET_PIN_DRIVE_EN), .ERASE_ALL(ERASE_ALL),
   .VERIFY_READ_EN(VERIFY_READ_EN));
`default_nettype wire

// ==== sim/swc_core_mdl.sv ====
// core model: issues sleep instructions, counts resumes and branches
// assumes the controller on the same clock
`timescale 1ns/10ps
`default_nettype none
`include "swc_defines.vh"

module swc_core_mdl (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic go,
   input wire logic [`SWC_PC_W-1:0] pc,
   input wire logic run,
   input wire logic resume,
   input wire logic vec,
   output var logic sleep_exec,
   output var logic [`SWC_PC_W-1:0] sleep_pc,
   output var int n_res,
   output var int n_vec
);
   // sleep only while running; address scrambled when not valid
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         sleep_exec <= 1'b0;
         sleep_pc <= '0;
         n_res <= 0;
         n_vec <= 0;
      end else begin
         sleep_exec <= go && run;
         sleep_pc <= go ? pc : ~sleep_pc;
         n_res <= n_res + int'(resume);
         n_vec <= n_vec + int'(vec);
      end
   end
endmodule
`default_nettype wire

// ==== sim/swc_testbench.sv ====
// self-checking bench of the sleep and wake controller
// assumes the core model and the bound checker beside the dut
`timescale 1ns/10ps
`default_nettype none
`include "swc_defines.vh"
`define CHK(n,e,g) begin checked++; if ((g) !== (e)) begin n_errors++; \
$display("BAD %s exp %0h got %0h", n, e, g); end end

module testbench;
   logic clk, arst_n, awv, wv, arv, watchdog_clear_instr, pin_n, cfg_en, prog, go;
   logic awr, wrr, bv, arr, rv, run, res, vec, osc, hold, dres, er;
   logic ver, sx, seen, wres;
   logic [7:0] awa, ara;
   logic [31:0] wd, rdat, rd_d, r;
   logic [1:0] br, rr, resp;
   logic [8:0] irq;
   logic [12:0] pc, spc;
   int n_errors, checked, cyc, n_res, n_vec, n_er, pd_n, to_n, r0, v0, n_wr;

   swc_sleep_ctrl #(.OST_CYCLES(8)) dut (
      .CLK_SYS(clk), .ARST_N(arst_n), .S_AXI_AWADDR(awa),
      .S_AXI_AWVALID(awv), .S_AXI_AWREADY(awr), .S_AXI_WDATA(wd),
      .S_AXI_WSTRB(4'hf), .S_AXI_WVALID(wv), .S_AXI_WREADY(wrr),
      .S_AXI_BRESP(br), .S_AXI_BVALID(bv), .S_AXI_BREADY(1'b1),
      .S_AXI_ARADDR(ara), .S_AXI_ARVALID(arv), .S_AXI_ARREADY(arr),
      .S_AXI_RDATA(rdat), .S_AXI_RRESP(rr), .S_AXI_RVALID(rv),
      .S_AXI_RREADY(1'b1), .SLEEP_EXEC(sx), .SLEEP_PC(spc),
      .WATCHDOG_CLEAR_INSTR_EXEC(watchdog_clear_instr), .CORE_RUN(run), .PREFETCH_REQ(),
      .PREFETCH_ADDR(), .RESUME_PULSE(res), .VECTOR_REQ(vec),
      .VECTOR_ADDR(), .IRQ_FLAGS(irq), .EXTERNAL_RESET_PIN_N(pin_n),
      .WATCHDOG_CONFIG_ENABLE(cfg_en), .PROG_MODE(prog),
      .OSC_DRIVER_EN(osc), .IO_HOLD(hold), .DEVICE_RESET(dres),
      .WDT_RESET(wres), .RESET_PIN_DRIVE_EN(), .ERASE_ALL(er),
      .VERIFY_READ_EN(ver));
   swc_core_mdl core (.clk(clk), .rst_n(arst_n), .go(go), .pc(pc),
      .run(run), .resume(res), .vec(vec), .sleep_exec(sx),
      .sleep_pc(spc), .n_res(n_res), .n_vec(n_vec));

   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end
   // erase and watchdog reset pulse counts, hang limit
   always @(posedge clk) begin
      cyc++;
      if (er === 1'b1) n_er++;
      if (wres === 1'b1) n_wr++;
      if (cyc == 20000) begin
         n_errors++;
         conclude();
      end
   end

   task automatic conclude();
      if (n_errors == 0 && checked > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask
   // write: address and data offered together, each dropped when taken
   task automatic axw(input logic [7:0] a, input logic [31:0] d);
      bit ta, tw;
      ta = 0;
      tw = 0;
      awa <= a;
      wd <= d;
      awv <= 1'b1;
      wv <= 1'b1;
      while (!(ta && tw)) begin
         @(posedge clk);
         if (!ta && awr) begin
            ta = 1;
            awv <= 1'b0;
         end
         if (!tw && wrr) begin
            tw = 1;
            wv <= 1'b0;
         end
      end
      do @(posedge clk); while (bv !== 1'b1);
      resp = br;
   endtask
   task automatic axr(input logic [7:0] a);
      ara <= a;
      arv <= 1'b1;
      do @(posedge clk); while (arr !== 1'b1);
      arv <= 1'b0;
      do @(posedge clk); while (rv !== 1'b1);
      rd_d = rdat;
      resp = rr;
   endtask
   task automatic st_chk();
      axr(`SWC_ADDR_STATUS);
      `CHK("status", 2'(pd_n * 2 + to_n), rd_d[1:0])
   endtask
   // core issues one sleep instruction at a random address
   task automatic sleep_go();
      pc <= 13'($urandom);
      go <= 1'b1;
      @(posedge clk);
      go <= 1'b0;
      repeat (3) @(posedge clk);
   endtask
   task automatic wake_wait();
      while (n_res == r0) @(posedge clk);
   endtask
   // sleep, then wake through one interrupt source
   task automatic nap(input int s, input logic g, input logic x);
      axw(`SWC_ADDR_CTRL, {27'h0, x, 2'b11, g, 1'b0});
      axw(`SWC_ADDR_IRQ_EN, 32'h1 << s);
      r0 = n_res;
      v0 = n_vec;
      sleep_go();
      `CHK("run", 1'b0, run)
      `CHK("osc", 1'b0, osc)
      `CHK("hold", 1'b1, hold)
      pd_n = 0;
      to_n = 1;
      st_chk();
      irq[s] <= 1'b1;
      wake_wait();
      irq[s] <= 1'b0;
      `CHK("vec", int'(g), n_vec - v0)
      `CHK("hold", 1'b0, hold)
   endtask

   initial begin
      arst_n = 1'b0;
      {awv, wv, arv, watchdog_clear_instr, cfg_en, prog, go} = '0;
      {pin_n, irq, awa, ara, wd, pc} = {1'b1, 70'h0};
      void'($urandom(88885));
      repeat (10) @(posedge clk);
      arst_n <= 1'b1;
      repeat (2) @(posedge clk);
      axr(`SWC_ADDR_CTRL);
      `CHK("ctrl", 32'h20, rd_d)
      `CHK("verify", 1'b0, ver)
      axr(`SWC_ADDR_WDT_PERIOD);
      `CHK("period", 32'h200, rd_d)
      pd_n = 1;
      to_n = 1;
      st_chk();
      cfg_en <= 1'b1;
      repeat (4) @(posedge clk);
      axr(`SWC_ADDR_STATUS);
      `CHK("wdt_on", 1'b1, rd_d[3])
      cfg_en <= 1'b0;
      // refused accesses
      axr(8'h40);
      `CHK("resp", `SWC_RESP_SLVERR, resp)
      axr(`SWC_ADDR_ID0);
      `CHK("resp", `SWC_RESP_SLVERR, resp)
      axw(`SWC_ADDR_STATUS, 32'h0);
      `CHK("resp", `SWC_RESP_SLVERR, resp)
      // id word in program mode keeps seven bits
      prog <= 1'b1;
      repeat (3) @(posedge clk);
      r = $urandom;
      axw(`SWC_ADDR_ID3, r);
      axr(`SWC_ADDR_ID3);
      `CHK("id", r & 32'h7f, rd_d)
      prog <= 1'b0;
      // code protect off erases and opens verify reads
      axw(`SWC_ADDR_CTRL, 32'h0);
      repeat (2) @(posedge clk);
      `CHK("erase", 1, n_er)
      `CHK("verify", 1'b1, ver)
      for (int s = 0; s < `SWC_IRQ_W; s++) nap(s, s[0], s == 3);
      // pending enabled flag without global enable: sleep does nothing
      watchdog_clear_instr <= 1'b1;
      @(posedge clk);
      watchdog_clear_instr <= 1'b0;
      pd_n = 1;
      to_n = 1;
      axw(`SWC_ADDR_IRQ_EN, 32'h40);
      axw(`SWC_ADDR_CTRL, 32'h0);
      irq[6] <= 1'b1;
      repeat (4) @(posedge clk);
      sleep_go();
      `CHK("run", 1'b1, run)
      st_chk();
      // with global enable the sleep completes, then wakes at once
      axw(`SWC_ADDR_CTRL, 32'h2);
      r0 = n_res;
      v0 = n_vec;
      sleep_go();
      wake_wait();
      irq[6] <= 1'b0;
      `CHK("vec", 1, n_vec - v0)
      pd_n = 0;
      st_chk();
      // synchronous timer cannot wake; the watchdog does
      axw(`SWC_ADDR_WDT_PERIOD, 32'd40);
      axw(`SWC_ADDR_IRQ_EN, 32'h1);
      irq[0] <= 1'b1;
      axw(`SWC_ADDR_CTRL, 32'h1);
      r0 = n_res;
      v0 = n_vec;
      sleep_go();
      repeat (20) @(posedge clk);
      `CHK("run", 1'b0, run)
      wake_wait();
      axw(`SWC_ADDR_CTRL, 32'h0);
      irq[0] <= 1'b0;
      `CHK("vec", 0, n_vec - v0)
      to_n = 0;
      st_chk();
      // reset pin during sleep: full reset and no resume
      axw(`SWC_ADDR_IRQ_EN, 32'h0);
      r0 = n_res;
      sleep_go();
      pin_n <= 1'b0;
      seen = 1'b0;
      repeat (6) begin
         @(posedge clk);
         seen = seen | dres;
      end
      pin_n <= 1'b1;
      repeat (6) @(posedge clk);
      `CHK("dres", 1'b1, seen)
      `CHK("run", 1'b1, run)
      `CHK("resume", r0, n_res)
      // watchdog expiry while running: one internal reset, flag marked
      watchdog_clear_instr <= 1'b1;
      @(posedge clk);
      watchdog_clear_instr <= 1'b0;
      axw(`SWC_ADDR_CTRL, 32'h1);
      repeat (50) @(posedge clk);
      axw(`SWC_ADDR_CTRL, 32'h0);
      `CHK("wdt_reset", 1, n_wr)
      pd_n = 1;
      to_n = 0;
      st_chk();
      conclude();
   end
endmodule
`default_nettype wire
